// [logic/bsch_consts.svh]
/*
  Constants of the serial command handler: characters, command codes,
  status codes, field sizes and timing.
  Assumes a 100 MHz core clock.
*/
`ifndef BSCH_CONSTS_SVH
`define BSCH_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define BSCH_CLK_KHZ 100000
`define BSCH_CHAR_TMO_MS 2000

// ----------------------------------------
// Characters
// ----------------------------------------
`define BSCH_CH_CR 8'h0D
`define BSCH_CH_LF 8'h0A
`define BSCH_CH_SP 8'h20
`define BSCH_CH_DOT 8'h2E
`define BSCH_CH_0 8'h30
`define BSCH_CH_9 8'h39
`define BSCH_CH_LC_A 8'h61
`define BSCH_CH_LC_Z 8'h7A
`define BSCH_CASE_BIT 8'h20

// ----------------------------------------
// Two-character command codes, upper case
// ----------------------------------------
`define BSCH_CMD_SELECT 16'h4944
`define BSCH_CMD_PRESET_WR 16'h4256
`define BSCH_CMD_STATE_Q 16'h4253
`define BSCH_CMD_HALT 16'h4248
`define BSCH_CMD_TOTAL_CLR 16'h4252
`define BSCH_CMD_GO 16'h4243
`define BSCH_CMD_TOTALS_Q 16'h543F
`define BSCH_CMD_RATE_Q 16'h523F
`define BSCH_CMD_PRESET_Q 16'h423F

// ----------------------------------------
// Status codes and replies
// ----------------------------------------
`define BSCH_ST_COMPLETE 4'h1
`define BSCH_MSG_INVALID 64'h20494E56414C4944
`define BSCH_FLD_BLANK 64'h2020202020202020
`define BSCH_NUM_MAX 27'h5F5E0FF
`define BSCH_MAX_DIGITS 4'h8

`endif

// [logic/bsch_pkg.sv]
/*
  Types shared by the command handler and its reply formatter.
  Assumes the constants header is included where numbers are needed.
*/
package bsch_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [63:0] bsch_field_t;
  typedef bsch_field_t [3:0] bsch_fields_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SCALE = 4'h2,
    ST_STAT = 4'h4,
    ST_SEND = 4'h8
  } bsch_state_e;

  typedef enum logic [3:0] {
    FS_FIELD = 4'h1,
    FS_SEP = 4'h2,
    FS_CR = 4'h4,
    FS_LF = 4'h8
  } bsch_fstage_e;

endpackage : bsch_pkg

// [logic/bsch_fmt_if.sv]
/*
  Carrier between the command handler and the reply formatter.
  Both ends run on the same core clock.
*/
interface bsch_fmt_if;
  logic start;
  logic [2:0] nfld;
  bsch_pkg::bsch_fields_t fld;
  logic busy;

  modport ctl (output start, output nfld, output fld, input busy);
  modport fmt (input start, input nfld, input fld, output busy);
endinterface : bsch_fmt_if

// [logic/bsch_reply_fmt.sv]
/*
  Reply formatter: sends up to four right-justified 8-character fields,
  leading spaces before each field's last character dropped, single spaces between, then CR LF.
  Assumes fields stay stable while busy is high.
*/
`include "bsch_consts.svh"

module bsch_reply_fmt (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Request from the handler
  bsch_fmt_if.fmt req,
  // Character stream out
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);

  bsch_pkg::bsch_fstage_e stage;
  logic busy;
  logic lead;
  logic [1:0] fi;
  logic [2:0] ci;
  logic [7:0] ch;
  logic go;
  logic skip;
  logic last_fld;

  assign req.busy = busy;
  assign ch = req.fld[fi][8'(ci) * 8 +: 8];
  assign go = busy && (!tx_valid || tx_ready);
  // Variable-length values: padding in front of a field's last character is never sent
  assign skip = (stage == bsch_pkg::FS_FIELD) && lead && (ch == `BSCH_CH_SP) && (ci != 3'h0);
  assign last_fld = ({1'b0, fi} == 3'(req.nfld - 3'h1));

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      stage <= bsch_pkg::FS_FIELD;
      lead <= 1'b1;
      fi <= 2'h0;
      ci <= 3'h7;
    end else if (req.start && !busy) begin
      busy <= 1'b1;
      stage <= bsch_pkg::FS_FIELD;
      lead <= 1'b1;
      fi <= 2'h0;
      ci <= 3'h7;
    end else if (go) begin
      case (stage)
        bsch_pkg::FS_FIELD: begin
          if (!skip) begin
            lead <= 1'b0;
          end
          if (ci == 3'h0) begin
            // Identifier leads, so fields go out in rising index order
            stage <= last_fld ? bsch_pkg::FS_CR : bsch_pkg::FS_SEP;
          end else begin
            ci <= ci - 3'h1;
          end
        end
        bsch_pkg::FS_SEP: begin
          fi <= fi + 2'h1;
          ci <= 3'h7;
          lead <= 1'b1;
          stage <= bsch_pkg::FS_FIELD;
        end
        bsch_pkg::FS_CR: begin
          stage <= bsch_pkg::FS_LF;
        end
        bsch_pkg::FS_LF: begin
          busy <= 1'b0;
        end
        default: begin
          busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Output character register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (go && !skip) begin
      tx_valid <= 1'b1;
      case (stage)
        bsch_pkg::FS_FIELD: tx_data <= ch;
        bsch_pkg::FS_SEP: tx_data <= `BSCH_CH_SP;
        bsch_pkg::FS_CR: tx_data <= `BSCH_CH_CR;
        bsch_pkg::FS_LF: tx_data <= `BSCH_CH_LF;
        default: tx_data <= `BSCH_CH_SP;
      endcase
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

endmodule : bsch_reply_fmt

// [logic/bsch_cmd.sv]
/*
  Line-oriented ASCII command handler for one unit on a multidrop line.
  Assumes a UART on the same core clock delivers received characters and
  takes transmitted ones by valid/ready; batch logic supplies the status
  code and display text, and acts on the one-cycle command pulses.
*/
`include "bsch_consts.svh"

module bsch_cmd #(
  parameter int unsigned TMO_CYC = `BSCH_CHAR_TMO_MS * `BSCH_CLK_KHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Received characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Transmitted characters
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Unit configuration
  input wire logic [6:0] unit_id,
  input wire logic [2:0] preset_dp,
  input wire logic [26:0] batch_lo,
  input wire logic [26:0] batch_hi,
  input wire logic count_down,
  // Batch state and display text, right-justified ASCII
  input wire logic [3:0] batch_status,
  input wire logic [63:0] ticket_txt,
  input wire logic [63:0] total_txt,
  input wire logic [63:0] accum_txt,
  input wire logic [63:0] rate_txt,
  input wire logic [63:0] preset_txt,
  // Actions toward the batch logic
  output logic stop_key,
  output logic run_key,
  output logic total_clear,
  output logic total_load,
  output logic preset_wr,
  output logic [26:0] preset_val,
  output logic selected
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    if (c >= `BSCH_CH_LC_A && c <= `BSCH_CH_LC_Z) begin
      to_upper = c & ~`BSCH_CASE_BIT;
    end else begin
      to_upper = c;
    end
  endfunction : to_upper

  function automatic logic [26:0] times10(input logic [26:0] v);
    times10 = 27'({v, 3'b000}) + 27'({v, 1'b0});
  endfunction : times10

  // Identifier as display text, no leading zero
  function automatic logic [63:0] id_text(input logic [6:0] id);
    logic [6:0] tens;
    logic [6:0] ones;
    logic [7:0] hi;
    tens = 7'(id / 7'd10);
    ones = 7'(id % 7'd10);
    hi = (tens == 7'h00) ? `BSCH_CH_SP : (`BSCH_CH_0 + {1'b0, tens});
    id_text = {48'h202020202020, hi, `BSCH_CH_0 + {1'b0, ones}};
  endfunction : id_text

  function automatic logic [63:0] code_text(input logic [3:0] code);
    code_text = {56'h20202020202020, `BSCH_CH_0 + {4'h0, code}};
  endfunction : code_text

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  bsch_fmt_if fmt_bus ();

  bsch_pkg::bsch_state_e state;
  logic [7:0] cmd_hi;
  logic [7:0] cmd_lo;
  logic [1:0] nchr;
  logic has_val;
  logic bad_val;
  logic seen_dp;
  logic [3:0] ndig;
  logic [2:0] nfrac;
  logic [2:0] nfrac_s;
  logic [26:0] val_acc;
  logic [31:0] idle_cnt;
  logic [7:0] rx_up;
  logic [3:0] dval;
  logic is_digit;
  logic take;
  logic line_end;
  logic tmo_hit;
  logic allowed;
  logic complete;
  logic [15:0] code;
  logic start;
  logic [2:0] nfld;
  bsch_pkg::bsch_fields_t fld;

  assign rx_ready = (state == bsch_pkg::ST_IDLE);
  assign take = rx_valid && rx_ready;
  assign rx_up = to_upper(rx_data);
  assign is_digit = (rx_data >= `BSCH_CH_0) && (rx_data <= `BSCH_CH_9);
  assign dval = 4'(rx_data - `BSCH_CH_0);
  assign line_end = take && (rx_data == `BSCH_CH_CR);
  assign tmo_hit = (nchr != 2'h0) && (idle_cnt >= TMO_CYC - 1);
  assign allowed = selected || (unit_id == 7'h00);
  assign complete = (batch_status == `BSCH_ST_COMPLETE);
  assign code = {cmd_hi, cmd_lo};

  assign fmt_bus.start = start;
  assign fmt_bus.nfld = nfld;
  assign fmt_bus.fld = fld;

  // ----------------------------------------
  // Character timeout
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt <= 32'h00000000;
    end else if (take || nchr == 2'h0) begin
      idle_cnt <= 32'h00000000;
    end else if (!tmo_hit) begin
      idle_cnt <= idle_cnt + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Input line buffer and value parse
  // ----------------------------------------
  // Only the two code letters are kept; the value is folded in as it
  // arrives, so no character store is needed.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_hi <= 8'h00;
      cmd_lo <= 8'h00;
      nchr <= 2'h0;
      has_val <= 1'b0;
      bad_val <= 1'b0;
      seen_dp <= 1'b0;
      ndig <= 4'h0;
      nfrac <= 3'h0;
    end else if (line_end || tmo_hit) begin
      nchr <= 2'h0;
      has_val <= 1'b0;
      bad_val <= 1'b0;
      seen_dp <= 1'b0;
      ndig <= 4'h0;
      nfrac <= 3'h0;
    end else if (take && rx_data >= `BSCH_CH_SP) begin
      if (nchr == 2'h0) begin
        cmd_hi <= rx_up;
        nchr <= 2'h1;
      end else if (nchr == 2'h1) begin
        cmd_lo <= rx_up;
        nchr <= 2'h2;
      end else begin
        has_val <= 1'b1;
        if (is_digit) begin
          if (ndig == `BSCH_MAX_DIGITS) begin
            bad_val <= 1'b1;
          end else begin
            ndig <= ndig + 4'h1;
          end
          if (seen_dp) begin
            nfrac <= nfrac + 3'h1;
          end
        end else if (rx_data == `BSCH_CH_DOT && !seen_dp) begin
          seen_dp <= 1'b1;
        end else begin
          bad_val <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Command execution
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= bsch_pkg::ST_IDLE;
      val_acc <= 27'h0000000;
      selected <= 1'b0;
      stop_key <= 1'b0;
      run_key <= 1'b0;
      total_clear <= 1'b0;
      total_load <= 1'b0;
      preset_wr <= 1'b0;
      preset_val <= 27'h0000000;
      start <= 1'b0;
      nfld <= 3'h1;
      fld <= {4{`BSCH_FLD_BLANK}};
    end else begin
      stop_key <= 1'b0;
      run_key <= 1'b0;
      total_clear <= 1'b0;
      total_load <= 1'b0;
      preset_wr <= 1'b0;
      start <= 1'b0;
      case (state)
        bsch_pkg::ST_IDLE: begin
          if (tmo_hit) begin
            val_acc <= 27'h0000000;
          end else if (take && is_digit && nchr == 2'h2 && ndig != `BSCH_MAX_DIGITS) begin
            val_acc <= times10(val_acc) + 27'(dval);
          end
          if (line_end && nchr == 2'h2) begin
            val_acc <= 27'h0000000;
            fld[0] <= id_text(unit_id);
            if (code == `BSCH_CMD_SELECT) begin
              if (has_val) begin
                if (!bad_val) begin
                  selected <= (val_acc == {20'h00000, unit_id});
                end
              end else if (allowed) begin
                nfld <= 3'h1;
                start <= 1'b1;
                state <= bsch_pkg::ST_SEND;
              end
            end else if (allowed) begin
              case (code)
                `BSCH_CMD_PRESET_WR: begin
                  if (complete && has_val && !bad_val) begin
                    val_acc <= val_acc;
                    state <= bsch_pkg::ST_SCALE;
                  end
                end
                `BSCH_CMD_STATE_Q: begin
                  state <= bsch_pkg::ST_STAT;
                end
                `BSCH_CMD_HALT: begin
                  stop_key <= 1'b1;
                  state <= bsch_pkg::ST_STAT;
                end
                `BSCH_CMD_TOTAL_CLR: begin
                  if (complete) begin
                    total_clear <= !count_down;
                    total_load <= count_down;
                  end
                  state <= bsch_pkg::ST_STAT;
                end
                `BSCH_CMD_GO: begin
                  run_key <= 1'b1;
                  state <= bsch_pkg::ST_STAT;
                end
                `BSCH_CMD_TOTALS_Q: begin
                  fld[1] <= ticket_txt;
                  fld[2] <= total_txt;
                  fld[3] <= accum_txt;
                  nfld <= 3'h4;
                  start <= 1'b1;
                  state <= bsch_pkg::ST_SEND;
                end
                `BSCH_CMD_RATE_Q: begin
                  fld[1] <= rate_txt;
                  nfld <= 3'h2;
                  start <= 1'b1;
                  state <= bsch_pkg::ST_SEND;
                end
                `BSCH_CMD_PRESET_Q: begin
                  fld[1] <= preset_txt;
                  nfld <= 3'h2;
                  start <= 1'b1;
                  state <= bsch_pkg::ST_SEND;
                end
                default: begin
                  fld[0] <= `BSCH_MSG_INVALID;
                  nfld <= 3'h1;
                  start <= 1'b1;
                  state <= bsch_pkg::ST_SEND;
                end
              endcase
            end
          end else if (line_end && nchr != 2'h0 && allowed) begin
            // A lone letter is never a valid code
            val_acc <= 27'h0000000;
            fld[0] <= `BSCH_MSG_INVALID;
            nfld <= 3'h1;
            start <= 1'b1;
            state <= bsch_pkg::ST_SEND;
          end else if (line_end) begin
            val_acc <= 27'h0000000;
          end
        end
        bsch_pkg::ST_SCALE: begin
          // Bring the typed value to the preset's own decimal places
          // One more decade above this would pass eight digits and wrap
          if (nfrac_s > preset_dp || val_acc > `BSCH_NUM_MAX ||
              (nfrac_s != preset_dp && val_acc > `BSCH_NUM_MAX / 27'h000000A)) begin
            state <= bsch_pkg::ST_IDLE;
            val_acc <= 27'h0000000;
          end else if (nfrac_s != preset_dp) begin
            val_acc <= times10(val_acc);
          end else begin
            if (val_acc >= batch_lo && val_acc <= batch_hi) begin
              preset_wr <= 1'b1;
              preset_val <= val_acc;
            end
            val_acc <= 27'h0000000;
            state <= bsch_pkg::ST_IDLE;
          end
        end
        bsch_pkg::ST_STAT: begin
          // One cycle late so the reply shows the state after the action
          fld[1] <= code_text(batch_status);
          nfld <= 3'h2;
          start <= 1'b1;
          state <= bsch_pkg::ST_SEND;
        end
        bsch_pkg::ST_SEND: begin
          // Input stays closed until the line feed has really left
          if (!start && !fmt_bus.busy && !tx_valid) begin
            state <= bsch_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= bsch_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Fraction count while scaling
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nfrac_s <= 3'h0;
    end else if (state == bsch_pkg::ST_IDLE) begin
      nfrac_s <= nfrac;
    end else if (state == bsch_pkg::ST_SCALE) begin
      nfrac_s <= nfrac_s + 3'h1;
    end
  end

  // ----------------------------------------
  // Reply formatter
  // ----------------------------------------
  // Replies are only ever started by an allowed unit, so an unselected
  // unit with a nonzero identifier stays silent on the shared line.
  bsch_reply_fmt u_fmt (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .req(fmt_bus.fmt),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

endmodule : bsch_cmd

// [dv/bsch_cmd_props.sv]
/*
  Checker for the serial command handler, bound to its top module.
  Assumes one core clock and the asynchronous active-low reset.
*/
`include "bsch_consts.svh"

module bsch_cmd_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Serial side
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // Configuration and batch state
  input wire logic [6:0] unit_id,
  input wire logic [26:0] batch_lo,
  input wire logic [26:0] batch_hi,
  input wire logic count_down,
  input wire logic [3:0] batch_status,
  // Actions
  input wire logic stop_key,
  input wire logic run_key,
  input wire logic total_clear,
  input wire logic total_load,
  input wire logic preset_wr,
  input wire logic [26:0] preset_val,
  input wire logic selected
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply char changed");
  property p_unsel_quiet;
    !selected && unit_id != 7'h00 |-> !tx_valid;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet) else $error("unselected unit sent");
  property p_stop_pulse;
    stop_key |=> !stop_key;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse too long");
  property p_one_action;
    $onehot0({stop_key, run_key, total_clear, total_load, preset_wr});
  endproperty
  a_one_action: assert property (p_one_action) else $error("two actions at once");
  property p_clear_mode;
    (total_clear |-> !count_down) and (total_load |-> count_down);
  endproperty
  a_clear_mode: assert property (p_clear_mode) else $error("wrong total reset kind");
  property p_clear_state;
    total_clear || total_load |-> batch_status == `BSCH_ST_COMPLETE;
  endproperty
  a_clear_state: assert property (p_clear_state) else $error("total reset not complete");
  property p_preset_lim;
    preset_wr |-> preset_val >= batch_lo && preset_val <= batch_hi;
  endproperty
  a_preset_lim: assert property (p_preset_lim) else $error("preset outside limits");
  property p_tx_busy;
    tx_valid |-> !rx_ready;
  endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("input open during reply");
  property p_key_reply;
    stop_key || run_key |-> ##[1:40] tx_valid;
  endproperty
  a_key_reply: assert property (p_key_reply) else $error("no status after key");

  c_preset: cover property (preset_wr);
  c_load: cover property (total_load);
  c_halt: cover property (stop_key ##[1:40] tx_valid);
endmodule : bsch_cmd_props

bind bsch_cmd bsch_cmd_props bsch_cmd_props_inst (.core_clk, .arst_n, .rx_ready, .tx_valid,
  .tx_data, .tx_ready, .unit_id, .batch_lo, .batch_hi, .count_down, .batch_status, .stop_key,
  .run_key, .total_clear, .total_load, .preset_wr, .preset_val, .selected);

// [dv/bsch_host.sv]
/*
  Host model on the multidrop line: sends command lines and collects replies.
  Assumes the handler's valid/ready character handshake on the core clock.
*/
module bsch_host (
  // Clock
  input wire logic core_clk,
  // Characters toward the unit
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Characters from the unit
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rq[$];
  bit slow = 1'b0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end

  // Slow mode takes a reply char only every other cycle
  always @(posedge core_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      rq.push_back(tx_data);
    end
  end

  // Chars go back to back, far inside the gap limit; released data is inverted
  task automatic send(input string s, input bit cr);
    string t;
    t = cr ? {s, "\015"} : s;
    @(posedge core_clk);
    for (int i = 0; i < t.len(); i++) begin
      rx_data <= t[i];
      rx_valid <= 1'b1;
      do @(negedge core_clk); while (rx_ready !== 1'b1);
      @(posedge core_clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~t[t.len() - 1];
  endtask : send
endmodule : bsch_host

// [dv/bsch_cmd_tb_top.sv]
/*
  Testbench of the serial command handler with a host model.
  Assumes a shortened character timeout and a 100 MHz clock.
*/
module bsch_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 200;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic [6:0] unit_id = 7'h05;
  logic [2:0] preset_dp = 3'h1;
  logic [26:0] batch_lo = 27'h0000064;
  logic [26:0] batch_hi = 27'h0001388;
  logic count_down = 1'b0;
  logic [3:0] batch_status = 4'h1;
  logic [63:0] ticket_txt = "    0042";
  logic [63:0] total_txt = "    12.5";
  logic [63:0] accum_txt = "   345.6";
  logic [63:0] rate_txt = "     7.8";
  logic [63:0] preset_txt = "    50.0";
  logic stop_key, run_key, total_clear, total_load, preset_wr, selected;
  logic [26:0] preset_val;
  int num_errors = 0;
  int samples_checked = 0;
  int n_stop = 0, n_run = 0, n_clr = 0, n_load = 0, n_pw = 0;

  bsch_cmd #(.TMO_CYC(TMO)) bsch_cmd_inst (.core_clk, .arst_n, .rx_valid, .rx_data, .rx_ready,
    .tx_valid, .tx_data, .tx_ready, .unit_id, .preset_dp, .batch_lo, .batch_hi, .count_down,
    .batch_status, .ticket_txt, .total_txt, .accum_txt, .rate_txt, .preset_txt, .stop_key,
    .run_key, .total_clear, .total_load, .preset_wr, .preset_val, .selected);
  bsch_host bsch_host_inst (.core_clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
    .tx_ready);

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    n_stop += (stop_key === 1'b1);
    n_run += (run_key === 1'b1);
    n_clr += (total_clear === 1'b1);
    n_load += (total_load === 1'b1);
    n_pw += (preset_wr === 1'b1);
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : check

  task automatic cmd(input string s, input bit cr = 1'b1);
    bsch_host_inst.rq.delete();
    bsch_host_inst.send(s, cr);
  endtask : cmd

  task automatic reply(input string e);
    string f;
    int n;
    f = {e, "\015\012"};
    n = 0;
    while (n < 400 && bsch_host_inst.rq.size() < f.len()) begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    check(bsch_host_inst.rq.size(), f.len());
    for (int k = 0; k < f.len(); k++) check(bsch_host_inst.rq[k], f[k]);
  endtask : reply

  // Silence is judged over a span well past the usual reply latency
  task automatic quiet;
    repeat (60) @(posedge core_clk);
    check(bsch_host_inst.rq.size(), 0);
  endtask : quiet

  task automatic set_status(input logic [3:0] s);
    @(posedge core_clk);
    batch_status <= s;
  endtask : set_status

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_select;
    cmd("BS");
    quiet();
    check(selected, 1'b0);
    cmd("ID005");
    quiet();
    check(selected, 1'b1);
    cmd("ID");
    reply("5");
  endtask : t_select

  task automatic t_status;
    for (int s = 1; s <= 8; s++) begin
      set_status(s[3:0]);
      bsch_host_inst.slow = s[0];
      cmd(s[0] ? "bs" : "BS");
      reply($sformatf("5 %0d", s));
    end
    bsch_host_inst.slow = 1'b0;
  endtask : t_status

  task automatic t_keys;
    cmd("BH");
    reply("5 8");
    set_status(4'h7);
    cmd("bh");
    reply("5 7");
    check(n_stop, 2);
    cmd("bc");
    reply("5 7");
    check(n_run, 1);
  endtask : t_keys

  task automatic t_clear;
    for (int m = 0; m < 3; m++) begin
      set_status((m == 2) ? 4'h2 : 4'h1);
      count_down <= m[0];
      cmd("BR");
      reply((m == 2) ? "5 2" : "5 1");
    end
    check(n_clr, 1);
    check(n_load, 1);
  endtask : t_clear

  task automatic t_preset;
    set_status(4'h1);
    cmd("BV12.5");
    quiet();
    check(n_pw, 1);
    check(preset_val, 27'h000007D);
    cmd("BV9");
    quiet();
    check(n_pw, 1);
    set_status(4'h2);
    cmd("BV20");
    quiet();
    check(n_pw, 1);
  endtask : t_preset

  task automatic t_query;
    cmd("T?");
    reply("5 0042 12.5 345.6");
    cmd("r?");
    reply("5 7.8");
    cmd("B?");
    reply("5 50.0");
    cmd("XY");
    reply("INVALID");
  endtask : t_query

  task automatic t_line;
    cmd("BS", 1'b0);
    quiet();
    bsch_host_inst.send("", 1'b1);
    reply("5 2");
    cmd("B", 1'b0);
    repeat (TMO + 10) @(posedge core_clk);
    bsch_host_inst.send("S", 1'b1);
    reply("INVALID");
  endtask : t_line

  task automatic t_id_zero;
    cmd("ID7");
    quiet();
    check(selected, 1'b0);
    @(posedge core_clk);
    unit_id <= 7'h00;
    cmd("BS");
    reply("0 2");
  endtask : t_id_zero

  task automatic results;
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Whole run needs under 2k cycles; the watchdog allows 20k
  initial begin
    #200000;
    num_errors++;
    results();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    t_select();
    t_status();
    t_keys();
    t_clear();
    t_preset();
    t_query();
    t_line();
    t_id_zero();
    results();
  end
endmodule : bsch_cmd_tb_top
